// file: src/pac_pkg.sv
// pac_pkg: register map, field positions and reset values for port a
// assumes an axi4-lite slave with 32-bit data, one word per register
package pac_pkg;
  localparam int unsigned PAC_ADDR_W = 8;
  localparam int unsigned PAC_PINS   = 6;

  // byte offsets, all of them our own placement
  localparam logic [7:0] PAC_OFS_VALUE  = 8'h00;
  localparam logic [7:0] PAC_OFS_DIR    = 8'h04;
  localparam logic [7:0] PAC_OFS_LATCH  = 8'h08;
  localparam logic [7:0] PAC_OFS_ANALOG = 8'h0c;
  localparam logic [7:0] PAC_OFS_STEER  = 8'h10;

  // reset values
  localparam logic [5:0] PAC_DIR_RST    = 6'h3f;
  localparam logic [5:0] PAC_ANALOG_RST = 6'h17;
  localparam logic [5:0] PAC_LATCH_RST  = 6'h00;
  localparam logic [7:0] PAC_STEER_RST  = 8'h00;

  // implemented bit masks
  localparam logic [5:0] PAC_DIR_WMASK    = 6'h37;
  localparam logic [5:0] PAC_LATCH_MASK   = 6'h37;
  localparam logic [5:0] PAC_ANALOG_MASK  = 6'h17;
  localparam logic [7:0] PAC_STEER_MASK   = 8'hef;

  // pin numbers
  localparam int unsigned PAC_IN_ONLY = 3;

  // steering field positions
  localparam int unsigned PAC_RX_CHOICE  = 7;
  localparam int unsigned PAC_SDO_CHOICE = 6;
  localparam int unsigned PAC_SS_CHOICE  = 5;
  localparam int unsigned PAC_TG_CHOICE  = 3;
  localparam int unsigned PAC_TX_CHOICE  = 2;
  localparam int unsigned PAC_PB_CHOICE  = 1;
  localparam int unsigned PAC_PA_CHOICE  = 0;

  localparam logic [1:0] PAC_RESP_OKAY   = 2'b00;
  localparam logic [1:0] PAC_RESP_SLVERR = 2'b10;
endpackage

// file: src/pac_pin_sync.sv
// pac_pin_sync: three-stage pin sampler with agreement filter
// assumes pins are asynchronous to aclk
`timescale 1ns/100ps
module pac_pin_sync #(
  parameter int unsigned WIDTH = 6
) (
  // clock and reset
  input  wire logic             aclk,
  input  wire logic             aresetn,
  input  wire logic             clk_en,
  // pins in, filtered level out
  input  wire logic [WIDTH-1:0] pin_raw,
  output logic      [WIDTH-1:0] pin_level
);
  logic [WIDTH-1:0] s1_ff;
  logic [WIDTH-1:0] s2_ff;
  logic [WIDTH-1:0] s3_ff;
  logic [WIDTH-1:0] lvl_ff;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s1_ff  <= '0;
      s2_ff  <= '0;
      s3_ff  <= '0;
      lvl_ff <= '0;
    end else if (clk_en) begin
      s1_ff <= pin_raw;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      // change only counts once stages two and three agree
      for (int i = 0; i < WIDTH; i++) begin
        if (s2_ff[i] == s3_ff[i]) begin
          lvl_ff[i] <= s3_ff[i];
        end
      end
    end
  end

  assign pin_level = lvl_ff;
endmodule

// file: src/pac_port.sv
// pac_port: six-pin general purpose port with output priority muxing
// assumes an axi4-lite master and peripherals giving out/enable pairs
//
// Summary of operation
// - six pin bits, upper bits read zero
// - direction one disables output driver unless a function is enabled on the pin
// - direction zero drives output latch when no function is enabled on the pin
// - a3 input only, direction reads one
// - a3 never driven, no output functions
// - port read gives pins, write latch
// - port write loads the write data straight into the latch
// - direction controls drivers even when analog
// - analog select forces digital reads zero
// - analog select leaves digital outputs working
// - first enabled function in each pin's list wins
// - a0 priority list
// - a1 and a2 priority lists
// - a5 priority list
// - steering leaves direction values untouched
`timescale 1ns/100ps
module pac_port
  import pac_pkg::*;
(
  // clock, reset, enable
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  input  wire logic                  clk_en,
  // axi4-lite write
  input  wire logic [PAC_ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  output logic [1:0]                 s_axi_bresp,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  // axi4-lite read
  input  wire logic [PAC_ADDR_W-1:0] s_axi_araddr,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  output logic [31:0]                s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  // pins, split in/out/enable
  input  wire logic [5:0]            pin_in,
  output logic      [5:0]            pin_out,
  output logic      [5:0]            pin_oe,
  // peripheral outputs, each a value and an enable
  input  wire logic                  programming_data,
  input  wire logic                  programming_data_en,
  input  wire logic                  programming_clock,
  input  wire logic                  programming_clock_en,
  input  wire logic                  debug_data,
  input  wire logic                  debug_data_en,
  input  wire logic                  debug_clock,
  input  wire logic                  debug_clock_en,
  input  wire logic                  dac_output,
  input  wire logic                  dac_output_en,
  input  wire logic                  modulator_output,
  input  wire logic                  modulator_output_en,
  input  wire logic                  serial_transmit_clock,
  input  wire logic                  serial_transmit_clock_en,
  input  wire logic                  serial_receive_data,
  input  wire logic                  serial_receive_data_en,
  input  wire logic                  spi_sdo,
  input  wire logic                  spi_sdo_en,
  input  wire logic                  spi_sck,
  input  wire logic                  spi_sck_en,
  input  wire logic                  i2c_scl,
  input  wire logic                  i2c_scl_en,
  input  wire logic                  i2c_sda,
  input  wire logic                  i2c_sda_en,
  input  wire logic                  pwm_output_a,
  input  wire logic                  pwm_output_a_en,
  input  wire logic                  pwm_output_b,
  input  wire logic                  pwm_output_b_en,
  input  wire logic                  sr_latch_q,
  input  wire logic                  sr_latch_q_en,
  input  wire logic                  sr_latch_q_inverted,
  input  wire logic                  sr_latch_q_inverted_en,
  input  wire logic                  comparator_one_output,
  input  wire logic                  comparator_one_output_en,
  input  wire logic                  oscillator_input,
  input  wire logic                  oscillator_input_en,
  input  wire logic                  oscillator_output,
  input  wire logic                  oscillator_output_en,
  input  wire logic                  system_clock_output,
  input  wire logic                  system_clock_output_en,
  input  wire logic                  timer_osc_output,
  input  wire logic                  timer_osc_output_en,
  input  wire logic                  timer_osc_input,
  input  wire logic                  timer_osc_input_en,
  input  wire logic                  reference_clock_output,
  input  wire logic                  reference_clock_output_en,
  // peripheral inputs, digital read after analog gating
  output logic      [5:0]            pin_digital_in,
  output logic                       serial_receive_data_in,
  output logic                       slave_select_in,
  output logic                       timer_gate_input
);
  import pac_pkg::*;

  logic [5:0] port_a_direction_ff;
  logic [5:0] port_a_output_latch_ff;
  logic [5:0] port_a_analog_select_ff;
  logic [7:0] alternate_pin_steer_ff;
  logic [5:0] pin_level;
  logic [5:0] port_a_value_reg;

  logic       aw_held_ff;
  logic       w_held_ff;
  logic [7:0] aw_addr_ff;
  logic [31:0] w_data_ff;
  logic [3:0] w_strb_ff;
  logic       bvalid_ff;
  logic [1:0] bresp_ff;
  logic       rvalid_ff;
  logic [1:0] rresp_ff;
  logic [31:0] rdata_ff;

  pac_pin_sync #(
    .WIDTH (PAC_PINS)
  ) u_sync (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .clk_en    (clk_en),
    .pin_raw   (pin_in),
    .pin_level (pin_level)
  );

  // analog pins read zero, a3 has no analog select
  assign port_a_value_reg = pin_level & ~port_a_analog_select_ff;
  assign pin_digital_in   = port_a_value_reg;

  // ---------------- bus slave, write side ----------------
  logic wr_go;
  assign wr_go = aw_held_ff && w_held_ff && !bvalid_ff;
  assign s_axi_awready = !aw_held_ff && !bvalid_ff;
  assign s_axi_wready  = !w_held_ff && !bvalid_ff;
  assign s_axi_bvalid  = bvalid_ff;
  assign s_axi_bresp   = bresp_ff;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_ff <= 1'b0;
      aw_addr_ff <= 8'h00;
    end else if (clk_en) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_ff <= 1'b1;
        aw_addr_ff <= s_axi_awaddr;
      end else if (wr_go) begin
        aw_held_ff <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held_ff <= 1'b0;
      w_data_ff <= 32'h0000_0000;
      w_strb_ff <= 4'h0;
    end else if (clk_en) begin
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_ff <= 1'b1;
        w_data_ff <= s_axi_wdata;
        w_strb_ff <= s_axi_wstrb;
      end else if (wr_go) begin
        w_held_ff <= 1'b0;
      end
    end
  end

  logic wr_hit;
  logic lane0;
  always_comb begin
    case (aw_addr_ff)
      PAC_OFS_VALUE, PAC_OFS_DIR, PAC_OFS_LATCH,
      PAC_OFS_ANALOG, PAC_OFS_STEER: wr_hit = 1'b1;
      default: wr_hit = 1'b0;
    endcase
  end
  assign lane0 = wr_go && w_strb_ff[0];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_ff <= 1'b0;
      bresp_ff  <= PAC_RESP_OKAY;
    end else if (clk_en) begin
      if (wr_go) begin
        bvalid_ff <= 1'b1;
        bresp_ff  <= wr_hit ? PAC_RESP_OKAY : PAC_RESP_SLVERR;
      end else if (s_axi_bready) begin
        bvalid_ff <= 1'b0;
      end
    end
  end

  // steering never touches this register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      port_a_direction_ff <= PAC_DIR_RST;
    end else if (clk_en && lane0 && aw_addr_ff == PAC_OFS_DIR) begin
      // a3 held at one regardless of the write
      port_a_direction_ff <= (w_data_ff[5:0] & PAC_DIR_WMASK)
                             | ~PAC_DIR_WMASK;
    end
  end

  // whole byte write: every latch bit comes from the write data, none from the pin levels
  logic [5:0] rmw_value;
  always_comb begin
    rmw_value = port_a_value_reg;
    rmw_value = w_data_ff[5:0];
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      port_a_output_latch_ff <= PAC_LATCH_RST;
    end else if (clk_en && lane0) begin
      if (aw_addr_ff == PAC_OFS_VALUE) begin
        port_a_output_latch_ff <= rmw_value & PAC_LATCH_MASK;
      end else if (aw_addr_ff == PAC_OFS_LATCH) begin
        port_a_output_latch_ff <= w_data_ff[5:0] & PAC_LATCH_MASK;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      port_a_analog_select_ff <= PAC_ANALOG_RST;
    end else if (clk_en && lane0 && aw_addr_ff == PAC_OFS_ANALOG) begin
      port_a_analog_select_ff <= w_data_ff[5:0] & PAC_ANALOG_MASK;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      alternate_pin_steer_ff <= PAC_STEER_RST;
    end else if (clk_en && lane0 && aw_addr_ff == PAC_OFS_STEER) begin
      alternate_pin_steer_ff <= w_data_ff[7:0] & PAC_STEER_MASK;
    end
  end

  // ---------------- bus slave, read side ----------------
  assign s_axi_arready = !rvalid_ff;
  assign s_axi_rvalid  = rvalid_ff;
  assign s_axi_rdata   = rdata_ff;
  assign s_axi_rresp   = rresp_ff;

  logic [31:0] rd_word;
  logic        rd_hit;
  always_comb begin
    rd_word = 32'h0000_0000;
    rd_hit  = 1'b1;
    // upper bits stay zero
    case (s_axi_araddr)
      PAC_OFS_VALUE:  rd_word[5:0] = port_a_value_reg;
      PAC_OFS_DIR:    rd_word[5:0] = port_a_direction_ff;
      PAC_OFS_LATCH:  rd_word[5:0] = port_a_output_latch_ff;
      PAC_OFS_ANALOG: rd_word[5:0] = port_a_analog_select_ff;
      PAC_OFS_STEER:  rd_word[7:0] = alternate_pin_steer_ff;
      default:        rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_ff <= 1'b0;
      rdata_ff  <= 32'h0000_0000;
      rresp_ff  <= PAC_RESP_OKAY;
    end else if (clk_en) begin
      if (s_axi_arvalid && !rvalid_ff) begin
        rvalid_ff <= 1'b1;
        rdata_ff  <= rd_word;
        rresp_ff  <= rd_hit ? PAC_RESP_OKAY : PAC_RESP_SLVERR;
      end else if (s_axi_rready) begin
        rvalid_ff <= 1'b0;
      end
    end
  end

  // ---------------- steering of movable functions ----------------
  logic rx_on_a5, sdo_on_a4, ss_on_a0, tg_on_a3, tx_on_a4;
  logic pb_on_a4, pa_on_a5;
  assign rx_on_a5  = alternate_pin_steer_ff[PAC_RX_CHOICE];
  assign sdo_on_a4 = alternate_pin_steer_ff[PAC_SDO_CHOICE];
  assign ss_on_a0  = alternate_pin_steer_ff[PAC_SS_CHOICE];
  assign tg_on_a3  = alternate_pin_steer_ff[PAC_TG_CHOICE];
  assign tx_on_a4  = alternate_pin_steer_ff[PAC_TX_CHOICE];
  assign pb_on_a4  = alternate_pin_steer_ff[PAC_PB_CHOICE];
  assign pa_on_a5  = alternate_pin_steer_ff[PAC_PA_CHOICE];

  assign serial_receive_data_in =
    rx_on_a5 ? port_a_value_reg[5] : port_a_value_reg[1];
  assign slave_select_in =
    ss_on_a0 ? port_a_value_reg[0] : port_a_value_reg[PAC_IN_ONLY];
  assign timer_gate_input =
    tg_on_a3 ? port_a_value_reg[PAC_IN_ONLY] : port_a_value_reg[4];

  // ---------------- output priority per pin ----------------
  // first enabled entry wins; analog mode does not block these
  logic [5:0] fn_en;
  logic [5:0] fn_val;
  always_comb begin
    fn_en  = 6'h00;
    fn_val = 6'h00;
    // a0
    if (programming_data_en) begin
      fn_en[0] = 1'b1; fn_val[0] = programming_data;
    end else if (debug_data_en) begin
      fn_en[0] = 1'b1; fn_val[0] = debug_data;
    end else if (dac_output_en) begin
      fn_en[0] = 1'b1; fn_val[0] = dac_output;
    end else if (modulator_output_en) begin
      fn_en[0] = 1'b1; fn_val[0] = modulator_output;
    end else if (serial_transmit_clock_en && !tx_on_a4) begin
      fn_en[0] = 1'b1; fn_val[0] = serial_transmit_clock;
    end else if (spi_sdo_en && !sdo_on_a4) begin
      fn_en[0] = 1'b1; fn_val[0] = spi_sdo;
    end else if (pwm_output_b_en && !pb_on_a4) begin
      fn_en[0] = 1'b1; fn_val[0] = pwm_output_b;
    end
    // a1
    if (programming_clock_en) begin
      fn_en[1] = 1'b1; fn_val[1] = programming_clock;
    end else if (debug_clock_en) begin
      fn_en[1] = 1'b1; fn_val[1] = debug_clock;
    end else if (i2c_scl_en) begin
      fn_en[1] = 1'b1; fn_val[1] = i2c_scl;
    end else if (serial_receive_data_en && !rx_on_a5) begin
      fn_en[1] = 1'b1; fn_val[1] = serial_receive_data;
    end else if (spi_sck_en) begin
      fn_en[1] = 1'b1; fn_val[1] = spi_sck;
    end
    // a2
    if (sr_latch_q_en) begin
      fn_en[2] = 1'b1; fn_val[2] = sr_latch_q;
    end else if (comparator_one_output_en) begin
      fn_en[2] = 1'b1; fn_val[2] = comparator_one_output;
    end else if (i2c_sda_en) begin
      fn_en[2] = 1'b1; fn_val[2] = i2c_sda;
    end else if (pwm_output_a_en && !pa_on_a5) begin
      fn_en[2] = 1'b1; fn_val[2] = pwm_output_a;
    end
    // a4
    if (oscillator_output_en) begin
      fn_en[4] = 1'b1; fn_val[4] = oscillator_output;
    end else if (system_clock_output_en) begin
      fn_en[4] = 1'b1; fn_val[4] = system_clock_output;
    end else if (timer_osc_output_en) begin
      fn_en[4] = 1'b1; fn_val[4] = timer_osc_output;
    end else if (reference_clock_output_en) begin
      fn_en[4] = 1'b1; fn_val[4] = reference_clock_output;
    end else if (serial_transmit_clock_en && tx_on_a4) begin
      fn_en[4] = 1'b1; fn_val[4] = serial_transmit_clock;
    end else if (spi_sdo_en && sdo_on_a4) begin
      fn_en[4] = 1'b1; fn_val[4] = spi_sdo;
    end else if (pwm_output_b_en && pb_on_a4) begin
      fn_en[4] = 1'b1; fn_val[4] = pwm_output_b;
    end
    // a5
    if (oscillator_input_en) begin
      fn_en[5] = 1'b1; fn_val[5] = oscillator_input;
    end else if (timer_osc_input_en) begin
      fn_en[5] = 1'b1; fn_val[5] = timer_osc_input;
    end else if (sr_latch_q_inverted_en) begin
      fn_en[5] = 1'b1; fn_val[5] = sr_latch_q_inverted;
    end else if (serial_receive_data_en && rx_on_a5) begin
      fn_en[5] = 1'b1; fn_val[5] = serial_receive_data;
    end else if (pwm_output_a_en && pa_on_a5) begin
      fn_en[5] = 1'b1; fn_val[5] = pwm_output_a;
    end
  end

  // direction or an enabled function turns the driver on; analog select is not looked at
  logic [5:0] drive_en;
  logic [5:0] drive_val;
  assign drive_en  = ~port_a_direction_ff | fn_en;
  assign drive_val = (fn_en & fn_val)
                     | (~fn_en & port_a_output_latch_ff);

  // a3 forced off: nothing may ever drive it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_oe  <= 6'h00;
      pin_out <= 6'h00;
    end else if (clk_en) begin
      pin_oe  <= drive_en & PAC_LATCH_MASK;
      pin_out <= drive_val & PAC_LATCH_MASK;
    end
  end
endmodule

// file: tb/pac_port_chk.sv
// pac_port_chk: port-level checks on pac_port
// assumes clk_en held high and a synchronous active-low reset
`timescale 1ns/100ps
module pac_port_chk (
  // clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // pins and read data
  input wire logic [5:0]  pin_out,
  input wire logic [5:0]  pin_oe,
  input wire logic        s_axi_rvalid,
  input wire logic [31:0] s_axi_rdata,
  // top-priority functions, plus debug data second on a0
  input wire logic        programming_data,
  input wire logic        programming_data_en,
  input wire logic        programming_clock,
  input wire logic        programming_clock_en,
  input wire logic        debug_data,
  input wire logic        debug_data_en,
  input wire logic        sr_latch_q,
  input wire logic        sr_latch_q_en,
  input wire logic        oscillator_output,
  input wire logic        oscillator_output_en,
  input wire logic        oscillator_input,
  input wire logic        oscillator_input_en
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a3_undriven_a: assert property (!pin_oe[3])
    else $error("a3 driven");
  prog_data_wins_a: assert property (programming_data_en |=>
    pin_oe[0] && pin_out[0] == $past(programming_data))
    else $error("a0 not given to programming data");
  debug_next_a: assert property (
    debug_data_en && !programming_data_en |=>
    pin_oe[0] && pin_out[0] == $past(debug_data))
    else $error("a0 not given to debug data");
  prog_clk_wins_a: assert property (programming_clock_en |=>
    pin_oe[1] && pin_out[1] == $past(programming_clock))
    else $error("a1 not given to programming clock");
  latch_q_wins_a: assert property (sr_latch_q_en |=>
    pin_oe[2] && pin_out[2] == $past(sr_latch_q))
    else $error("a2 not given to latch output");
  osc_out_wins_a: assert property (oscillator_output_en |=>
    pin_oe[4] && pin_out[4] == $past(oscillator_output))
    else $error("a4 not given to oscillator output");
  osc_in_wins_a: assert property (oscillator_input_en |=>
    pin_oe[5] && pin_out[5] == $past(oscillator_input))
    else $error("a5 not given to oscillator input");
  upper_zero_a: assert property (
    s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("upper read bits set");
endmodule

bind pac_port pac_port_chk pac_port_chk_inst (.*);

// file: tb/pac_pin_env.sv
// pac_pin_env: board side of the six pins
// assumes the device driver wins over any outside driver
`timescale 1ns/100ps
module pac_pin_env (
  // clock
  input  wire logic       aclk,
  // device side
  input  wire logic [5:0] pin_out,
  input  wire logic [5:0] pin_oe,
  // outside drivers
  input  wire logic [5:0] ext_val,
  input  wire logic [5:0] ext_en,
  // wire level
  output logic      [5:0] pin_in
);
  logic [5:0] flt_ff = 6'h15;

  // undriven wire wanders, so a stale level never passes for a read
  always_ff @(posedge aclk) begin
    flt_ff <= ~flt_ff;
  end
  always_comb begin
    pin_in = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_val)
           | (~pin_oe & ~ext_en & flt_ff);
  end
endmodule

// file: tb/pac_port_test.sv
// pac_port_test: register, pin and priority tests for pac_port
// assumes pac_pin_env stands for the board and the checker is bound
`timescale 1ns/100ps
module pac_port_test;
  logic        aclk = 1'h0, aresetn = 1'h0, clk_en = 1'h1;
  logic [7:0]  s_axi_awaddr = '0, s_axi_araddr = '0;
  logic        s_axi_awvalid = '0, s_axi_wvalid = '0, s_axi_bready = '0;
  logic        s_axi_arvalid = '0, s_axi_rready = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata, g;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic        s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp, x, r;
  logic [5:0]  pin_in, pin_out, pin_oe, pin_digital_in;
  logic [5:0]  ext_val = '0, ext_en = '0;
  logic        serial_receive_data_in, slave_select_in, timer_gate_input;
  logic [22:0] pv = '0, pe = '0, te, tv;
  logic [7:0]  a, d, e;
  int          n_fail = 0, compares = 0;
  // address, write data, expected read, expected response
  logic [25:0] rows [8] = '{
    {8'h04, 8'h00, 8'h08, 2'h0}, {8'h04, 8'hff, 8'h3f, 2'h0},
    {8'h08, 8'hff, 8'h37, 2'h0}, {8'h08, 8'h15, 8'h15, 2'h0},
    {8'h0c, 8'hff, 8'h17, 2'h0}, {8'h0c, 8'h00, 8'h00, 2'h0},
    {8'h10, 8'hff, 8'hef, 2'h0}, {8'h14, 8'h5a, 8'h00, 2'h2}};
  // function indices per steer setting and pin, winner first
  int pl [2][6][8] = '{
    '{'{0,2,4,5,6,8,13,-1}, '{1,3,10,7,9,-1,-1,-1},
      '{14,16,11,12,-1,-1,-1,-1}, '{default: -1},
      '{18,19,20,22,-1,-1,-1,-1}, '{17,21,15,-1,-1,-1,-1,-1}},
    '{'{0,2,4,5,-1,-1,-1,-1}, '{1,3,10,9,-1,-1,-1,-1},
      '{14,16,11,-1,-1,-1,-1,-1}, '{default: -1},
      '{18,19,20,22,6,8,13,-1}, '{17,21,15,7,12,-1,-1,-1}}};

  pac_port pac_port_inst (
    .*,
    .programming_data(pv[0]), .programming_data_en(pe[0]),
    .programming_clock(pv[1]), .programming_clock_en(pe[1]),
    .debug_data(pv[2]), .debug_data_en(pe[2]),
    .debug_clock(pv[3]), .debug_clock_en(pe[3]),
    .dac_output(pv[4]), .dac_output_en(pe[4]),
    .modulator_output(pv[5]), .modulator_output_en(pe[5]),
    .serial_transmit_clock(pv[6]), .serial_transmit_clock_en(pe[6]),
    .serial_receive_data(pv[7]), .serial_receive_data_en(pe[7]),
    .spi_sdo(pv[8]), .spi_sdo_en(pe[8]),
    .spi_sck(pv[9]), .spi_sck_en(pe[9]),
    .i2c_scl(pv[10]), .i2c_scl_en(pe[10]),
    .i2c_sda(pv[11]), .i2c_sda_en(pe[11]),
    .pwm_output_a(pv[12]), .pwm_output_a_en(pe[12]),
    .pwm_output_b(pv[13]), .pwm_output_b_en(pe[13]),
    .sr_latch_q(pv[14]), .sr_latch_q_en(pe[14]),
    .sr_latch_q_inverted(pv[15]), .sr_latch_q_inverted_en(pe[15]),
    .comparator_one_output(pv[16]), .comparator_one_output_en(pe[16]),
    .oscillator_input(pv[17]), .oscillator_input_en(pe[17]),
    .oscillator_output(pv[18]), .oscillator_output_en(pe[18]),
    .system_clock_output(pv[19]), .system_clock_output_en(pe[19]),
    .timer_osc_output(pv[20]), .timer_osc_output_en(pe[20]),
    .timer_osc_input(pv[21]), .timer_osc_input_en(pe[21]),
    .reference_clock_output(pv[22]), .reference_clock_output_en(pe[22])
  );
  pac_pin_env pac_pin_env_inst (.*);

  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask

  task automatic chk(input string nm, input logic [31:0] ev, gv);
    compares++;
    if (gv !== ev) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", nm, ev, gv);
    end
  endtask

  // bready held from the start; stale response stays x on timeout
  task automatic wr(input logic [7:0] ad, dt, output logic [1:0] rs);
    rs = 2'hx;
    @(posedge aclk);
    s_axi_awaddr <= ad;
    s_axi_wdata <= {24'h0, dt};
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    repeat (50) begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
      if (s_axi_bvalid) begin
        rs = s_axi_bresp;
        break;
      end
    end
    s_axi_bready <= 1'h0;
  endtask

  task automatic rd(input logic [7:0] ad, output logic [31:0] dt,
                    output logic [1:0] rs);
    dt = 32'hx;
    rs = 2'hx;
    @(posedge aclk);
    s_axi_araddr <= ad;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    repeat (50) begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
      if (s_axi_rvalid) begin
        dt = s_axi_rdata;
        rs = s_axi_rresp;
        break;
      end
    end
    s_axi_rready <= 1'h0;
  endtask

  task automatic wo(input logic [7:0] ad, dt);
    logic [1:0] rs;
    wr(ad, dt, rs);
    chk("bresp", 2'h0, rs);
  endtask

  task automatic rc(input logic [7:0] ad, input logic [31:0] ev);
    logic [31:0] dt;
    logic [1:0]  rs;
    rd(ad, dt, rs);
    chk("rdata", ev, dt);
    chk("rresp", 2'h0, rs);
  endtask

  task automatic conclude();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  initial begin
    forever #50 aclk = ~aclk;
  end

  // whole run needs a few hundred cycles
  initial begin
    cyc(20000);
    n_fail++;
    conclude();
  end

  initial begin
    cyc(16);
    aresetn <= 1'h1;
    foreach (rows[i]) begin
      {a, d, e, x} = rows[i];
      wr(a, d, r);
      chk("bresp", x, r);
      rd(a, g, r);
      chk("rdata", e, g);
      chk("rresp", x, r);
    end
    $display("register rows done");
    ext_en <= 6'h08;
    ext_val <= 6'h08;
    wo(8'h0c, 8'h00);
    wo(8'h04, 8'h00);
    wo(8'h00, 8'h25);
    cyc(8);
    chk("pin_oe", 6'h37, pin_oe);
    chk("pin_out", 6'h25, pin_out);
    rc(8'h08, 8'h25);
    rc(8'h00, 8'h2d);
    wo(8'h0c, 8'h17);
    cyc(2);
    rc(8'h00, 8'h28);
    chk("pin_digital_in", 6'h28, pin_digital_in);
    chk("pin_oe", 6'h37, pin_oe);
    chk("pin_out", 6'h25, pin_out);
    wo(8'h04, 8'hff);
    wo(8'h0c, 8'h00);
    ext_en <= 6'h3f;
    ext_val <= 6'h0a;
    cyc(8);
    chk("pin_oe", 6'h00, pin_oe);
    rc(8'h00, 8'h0a);
    rc(8'h08, 8'h25);
    wo(8'h10, 8'h00);
    chk("rx_in", 1'h1, serial_receive_data_in);
    chk("ss_in", 1'h1, slave_select_in);
    chk("gate_in", 1'h0, timer_gate_input);
    wo(8'h10, 8'hff);
    chk("rx_in", 1'h0, serial_receive_data_in);
    chk("ss_in", 1'h0, slave_select_in);
    chk("gate_in", 1'h1, timer_gate_input);
    $display("pin tests done");
    ext_en <= 6'h00;
    wo(8'h0c, 8'h17);
    for (int s = 0; s < 2; s++) begin
      wo(8'h10, s ? 8'hff : 8'h00);
      rc(8'h04, 8'h3f);
      for (int p = 0; p < 6; p++)
        for (int k = 0; k < 8 && pl[s][p][k] >= 0; k++)
          for (int v = 0; v < 2; v++) begin
            te = '0;
            tv = '0;
            for (int j = k; j < 8 && pl[s][p][j] >= 0; j++) begin
              te[pl[s][p][j]] = 1'h1;
              tv[pl[s][p][j]] = (j == k) ? v[0] : !v[0];
            end
            pe <= te;
            pv <= tv;
            cyc(2);
            chk("pin_out", v, pin_out[p]);
            chk("pin_oe", 1'h1, pin_oe[p]);
          end
    end
    pe <= '0;
    $display("priority tests done");
    // clk_en low must freeze the pin registers
    cyc(2);
    clk_en <= 1'h0;
    pe[4] <= 1'h1;
    pv[4] <= 1'h1;
    cyc(3);
    chk("pin_oe", 6'h00, pin_oe);
    clk_en <= 1'h1;
    cyc(2);
    chk("pin_oe", 6'h01, pin_oe);
    chk("pin_out", 1'h1, pin_out[0]);
    pe <= '0;
    wo(8'h0c, 8'h00);
    wo(8'h04, 8'h00);
    $display("clock enable test done");
    // second reset in mid-run, registers were all moved off reset
    aresetn <= 1'h0;
    cyc(16);
    aresetn <= 1'h1;
    rc(8'h04, 8'h3f);
    rc(8'h0c, 8'h17);
    rc(8'h08, 8'h00);
    rc(8'h10, 8'h00);
    chk("pin_oe", 6'h00, pin_oe);
    chk("pin_out", 6'h00, pin_out);
    $display("reset test done");
    conclude();
  end
endmodule
